/* File: logic/bzfo_defines.svh */
// Register offsets, field positions, reset values and counts of the buzzer tone block.
`ifndef BZFO_DEFINES_SVH
`define BZFO_DEFINES_SVH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define BZFO_OFS_PWM_CTRL      4'h0
`define BZFO_OFS_PORT_DATA     4'h4
`define BZFO_OFS_PORT_DIR      4'h8
`define BZFO_OFS_TB_SRC        4'hC
`define BZFO_ADDR_WIDTH        4

// ==========================================================================
// Field positions
// ==========================================================================
`define BZFO_FREQ_LSB          0
`define BZFO_FREQ_MSB          2
`define BZFO_PIN_LSB           3
`define BZFO_PIN_MSB           4
`define BZFO_PWM_LSB           5
`define BZFO_PWM_MSB           7
`define BZFO_BIT6              6
`define BZFO_BIT7              7
`define BZFO_TB_LSB            0
`define BZFO_TB_MSB            1
`define BZFO_STAT_IN6          0
`define BZFO_STAT_IN7          1
`define BZFO_STAT_TONE         2

// ==========================================================================
// Reset values
// ==========================================================================
`define BZFO_RST_PWM_CTRL      8'h00
`define BZFO_RST_PORT_DATA     2'h0
`define BZFO_RST_PORT_DIR      2'h3
`define BZFO_RST_TB_SRC        2'h0

// ==========================================================================
// Counts
// ==========================================================================
`define BZFO_SYS_PRESCALE      4
`define BZFO_DIV_WIDTH         9
`define BZFO_FREQ_BASE_BIT     1

`endif

/* File: logic/bzfo_pkg.sv */
// Types shared by the buzzer tone block.
package bzfo_pkg;

    typedef enum logic [1:0] {
        BZFO_PIN_IO      = 2'h0,
        BZFO_PIN_SINGLE  = 2'h1,
        BZFO_PIN_RSVD    = 2'h2,
        BZFO_PIN_PAIR    = 2'h3
    } bzfo_pin_mode_type;

    typedef enum logic [1:0] {
        BZFO_TB_EXT_XTAL = 2'h0,
        BZFO_TB_INT_RC   = 2'h1,
        BZFO_TB_SYS_DIV  = 2'h2,
        BZFO_TB_SYS_ALT  = 2'h3
    } bzfo_tb_src_type;

endpackage

/* File: logic/bzfo_divider.sv */
// Free-running power-of-two divider that turns time-base ticks into the buzzer tone.
`timescale 1ns/10ps
`include "bzfo_defines.svh"

module bzfo_divider #(
    parameter int WIDTH = `BZFO_DIV_WIDTH
) (
    input  wire logic       sys_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       tick_i,
    input  wire logic [2:0] freq_sel_i,
    output logic            tone_o
);

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic             next_tone;

    // ======================================================================
    // Counter and tap selection
    // ======================================================================
    always_comb begin
        next_count = tick_i ? WIDTH'(count + 1'b1) : count; // RL11
        next_tone  = count[4'(freq_sel_i) + 4'(`BZFO_FREQ_BASE_BIT)]; // RL1
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count  <= '0;
            tone_o <= 1'b0;
        end else begin
            count  <= next_count;
            tone_o <= next_tone;
        end
    end

endmodule // bzfo_divider

/* File: logic/bzfo_top.sv */
// Buzzer tone generator with its pin-sharing logic and Avalon-MM register slave.
//
// Summary of operation
// RL1: Tone is time-base clock divided by 2^(code+2), code 000 to 111.
// RL2: Pin-mode field: 00 both I/O, 01 bit6 buzzer, 11 pair, 10 reserved.
// RL3: In pair mode bit7 pin carries the inverse of the bit6 tone.
// RL4: Pair mode, both outputs: tone only while bit6 data is 1, else low.
// RL5: Bit7 data bit has no effect while bit7 acts as inverted buzzer.
// RL6: Single mode: bit6 toned when output and data 1, low when data 0.
// RL7: A pin whose direction bit says input is always an input.
// RL8: Bit6 input and bit7 output: bit7 driven from its own data bit.
// RL9: Time base from external crystal, internal RC, or system clock over 4.
// RL10: Software sets both directions to output and gates the pair with bit6 data.
// RL11: Divider is a free-running counter; control register clears at reset.
`timescale 1ns/10ps
`include "bzfo_defines.svh"

module bzfo_top #(
    parameter int DIV_WIDTH = `BZFO_DIV_WIDTH
) (
    input  wire logic        sys_clk_i,
    input  wire logic        nrst_i,
    // Avalon-MM slave.
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Time-base sources, sampled as synchronous levels.
    input  wire logic        ext_low_xtal_i,
    input  wire logic        int_low_rc_i,
    // Shared port pins.
    input  wire logic        port_a_bit6_i,
    output logic             port_a_bit6_o,
    output logic             port_a_bit6_oe_o,
    input  wire logic        port_a_bit7_i,
    output logic             port_a_bit7_o,
    output logic             port_a_bit7_oe_o
);

    // ======================================================================
    // Local functions
    // ======================================================================
    // Rising-edge detect of a sampled level.
    function automatic logic rise(input logic now, input logic was);
        rise = now & ~was;
    endfunction

    // Byte lane 0 write strobe for a given register offset.
    function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs, input logic strobe,
                                 input logic lane0);
        hit = strobe & lane0 & (addr == ofs);
    endfunction

    // ======================================================================
    // Bus handshake
    // ======================================================================
    // Every access holds one wait cycle; the second edge completes it.
    // Read data are registered in that wait cycle, so there is no combinational
    // path from the register file to the read data port.
    logic bus_ack;
    logic next_bus_ack;
    logic bus_req;
    logic bus_done;

    assign bus_req           = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = bus_req & ~bus_ack;
    assign bus_done          = bus_req & bus_ack;
    // Acknowledge drops at the completing edge, so back-to-back requests are safe.

    always_comb begin
        next_bus_ack = bus_req & ~bus_ack;
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= next_bus_ack;
        end
    end

    // ======================================================================
    // Registers
    // ======================================================================
    logic [7:0]              pwm_ctrl;
    logic [7:0]              next_pwm_ctrl;
    logic [1:0]              port_data;
    logic [1:0]              next_port_data;
    logic [1:0]              port_dir;
    logic [1:0]              next_port_dir;
    bzfo_pkg::bzfo_tb_src_type tb_src;
    bzfo_pkg::bzfo_tb_src_type next_tb_src;
    logic                    wr_go;

    assign wr_go = avs_write_i & bus_done;

    // Only byte lane 0 carries register bits; a write without it is dropped.
    // Direction bits are stored as written: a 1 makes the pin an input.
    // The control register clears at reset, so both pins start as plain I/O.
    always_comb begin
        next_pwm_ctrl  = pwm_ctrl;
        next_port_data = port_data;
        next_port_dir  = port_dir;
        next_tb_src    = tb_src;
        if (hit(avs_address_i, `BZFO_OFS_PWM_CTRL, wr_go, avs_byteenable_i[0])) begin
            next_pwm_ctrl = avs_writedata_i[7:0];
        end
        if (hit(avs_address_i, `BZFO_OFS_PORT_DATA, wr_go, avs_byteenable_i[0])) begin
            next_port_data = avs_writedata_i[`BZFO_BIT7:`BZFO_BIT6];
        end
        if (hit(avs_address_i, `BZFO_OFS_PORT_DIR, wr_go, avs_byteenable_i[0])) begin
            next_port_dir = avs_writedata_i[`BZFO_BIT7:`BZFO_BIT6]; // RL7
        end
        if (hit(avs_address_i, `BZFO_OFS_TB_SRC, wr_go, avs_byteenable_i[0])) begin
            next_tb_src = bzfo_pkg::bzfo_tb_src_type'(avs_writedata_i[`BZFO_TB_MSB:`BZFO_TB_LSB]);
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pwm_ctrl  <= `BZFO_RST_PWM_CTRL; // RL11
            port_data <= `BZFO_RST_PORT_DATA;
            port_dir  <= `BZFO_RST_PORT_DIR;
            tb_src    <= bzfo_pkg::bzfo_tb_src_type'(`BZFO_RST_TB_SRC);
        end else begin
            pwm_ctrl  <= next_pwm_ctrl;
            port_data <= next_port_data;
            port_dir  <= next_port_dir;
            tb_src    <= next_tb_src;
        end
    end

    // ======================================================================
    // Read data
    // ======================================================================
    // Data is captured in the wait cycle and stands at the completing edge.
    logic [31:0] next_readdata;
    logic [2:0]  status;
    logic        tone;

    // The status bits let software see both pin levels and the live tone.
    // They are sampled in the wait cycle like every other register.
    assign status = {tone, port_a_bit7_i, port_a_bit6_i};

    always_comb begin
        // Read data hold their last value between reads.
        next_readdata = avs_readdata_o;
        if (avs_read_i & ~bus_ack) begin
            next_readdata = 32'h0000_0000;
            unique case (avs_address_i)
                `BZFO_OFS_PWM_CTRL: begin
                    next_readdata[7:0] = pwm_ctrl;
                end
                `BZFO_OFS_PORT_DATA: begin
                    next_readdata[`BZFO_BIT7:`BZFO_BIT6] = port_data;
                    next_readdata[`BZFO_STAT_TONE:`BZFO_STAT_IN6] = status;
                end
                `BZFO_OFS_PORT_DIR: begin
                    next_readdata[`BZFO_BIT7:`BZFO_BIT6] = port_dir;
                end
                `BZFO_OFS_TB_SRC: begin
                    next_readdata[`BZFO_TB_MSB:`BZFO_TB_LSB] = tb_src;
                end
                // Unmapped offsets read as zero.
                default: begin
                    next_readdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else begin
            avs_readdata_o <= next_readdata;
        end
    end

    // ======================================================================
    // Time-base selection
    // ======================================================================
    logic       xtal_q;
    logic       rc_q;
    logic [1:0] pre_cnt;
    logic       next_xtal_q;
    logic       next_rc_q;
    logic [1:0] next_pre_cnt;
    logic       sys_tick;
    logic       tb_tick;

    // The slow sources are levels counted on their rising edges, so the divider
    // advances once per time-base period whatever the source.
    // Both system clock codes give the divided-by-four tick.
    assign sys_tick = (pre_cnt == 2'(`BZFO_SYS_PRESCALE - 1));

    always_comb begin
        // The source levels are kept one cycle to find their rising edges.
        next_xtal_q  = ext_low_xtal_i;
        next_rc_q    = int_low_rc_i;
        next_pre_cnt = sys_tick ? 2'h0 : 2'(pre_cnt + 1'b1);
        unique case (tb_src) // RL9
            bzfo_pkg::BZFO_TB_EXT_XTAL: tb_tick = rise(ext_low_xtal_i, xtal_q);
            bzfo_pkg::BZFO_TB_INT_RC:   tb_tick = rise(int_low_rc_i, rc_q);
            bzfo_pkg::BZFO_TB_SYS_DIV:  tb_tick = sys_tick;
            bzfo_pkg::BZFO_TB_SYS_ALT:  tb_tick = sys_tick;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            xtal_q  <= 1'b0;
            rc_q    <= 1'b0;
            pre_cnt <= 2'h0;
        end else begin
            xtal_q  <= next_xtal_q;
            rc_q    <= next_rc_q;
            pre_cnt <= next_pre_cnt;
        end
    end

    // ======================================================================
    // Tone divider
    // ======================================================================
    // The divider runs freely; a new frequency code only moves the tap, so
    // the period in progress may once come out shorter or longer.
    bzfo_divider #(
        .WIDTH      (DIV_WIDTH)
    ) u_divider (
        .sys_clk_i  (sys_clk_i),
        .nrst_i     (nrst_i),
        .tick_i     (tb_tick),
        .freq_sel_i (pwm_ctrl[`BZFO_FREQ_MSB:`BZFO_FREQ_LSB]),
        .tone_o     (tone)
    );

    // ======================================================================
    // Pin function
    // ======================================================================
    // Direction bit 0 means output; the reserved mode acts as plain I/O.
    bzfo_pkg::bzfo_pin_mode_type pin_mode;
    logic next_pin6;
    logic next_pin7;
    logic next_oe6;
    logic next_oe7;
    logic buzz6;
    logic buzz7;

    // The pins are registered so that the pads never see a decode glitch.
    // The tone reaches a pin two edges after the divider counter steps.
    assign pin_mode = bzfo_pkg::bzfo_pin_mode_type'(pwm_ctrl[`BZFO_PIN_MSB:`BZFO_PIN_LSB]);

    always_comb begin
        unique case (pin_mode) // RL2
            bzfo_pkg::BZFO_PIN_SINGLE: begin
                buzz6 = 1'b1;
                buzz7 = 1'b0;
            end
            bzfo_pkg::BZFO_PIN_PAIR: begin
                buzz6 = 1'b1;
                buzz7 = ~port_dir[0]; // RL8
            end
            // The reserved pin-mode code falls back to plain I/O.
            bzfo_pkg::BZFO_PIN_IO, bzfo_pkg::BZFO_PIN_RSVD: begin
                buzz6 = 1'b0;
                buzz7 = 1'b0;
            end
        endcase
        next_oe6  = ~port_dir[0]; // RL7
        next_oe7  = ~port_dir[1]; // RL7
        next_pin6 = buzz6 ? (port_data[0] & tone) : port_data[0]; // RL6
        // The paired pin is gated by the bit-6 data bit only.
        next_pin7 = buzz7 ? (port_data[0] & ~tone) : port_data[1]; // RL3 RL4 RL5
        if (!next_oe6) begin
            next_pin6 = 1'b0;
        end
        if (!next_oe7) begin
            next_pin7 = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            port_a_bit6_o    <= 1'b0;
            port_a_bit7_o    <= 1'b0;
            // Both pins are released at reset and act as inputs.
            port_a_bit6_oe_o <= 1'b0;
            port_a_bit7_oe_o <= 1'b0;
        end else begin
            port_a_bit6_o    <= next_pin6;
            port_a_bit7_o    <= next_pin7;
            port_a_bit6_oe_o <= next_oe6;
            port_a_bit7_oe_o <= next_oe7;
        end
    end

endmodule // bzfo_top

/* File: testbench/bzfo_assertions.sv */
// Concurrent checks on the buzzer block's pins and register bus.
`timescale 1ns/10ps
`include "bzfo_defines.svh"
module bzfo_assertions (
    input wire logic        sys_clk_i,
    input wire logic        nrst_i,
    input wire logic [3:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        port_a_bit6_o,
    input wire logic        port_a_bit6_oe_o,
    input wire logic        port_a_bit7_o,
    input wire logic        port_a_bit7_oe_o
);
    // ==========================================================
    // Shadow copies of the registers that steer the pins
    // ==========================================================
    logic [7:0] ctrl, next_ctrl;
    logic [1:0] dir, next_dir, dat, next_dat;
    logic       hit, pair, single;
    assign hit = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
    assign pair = ctrl[4:3] == bzfo_pkg::BZFO_PIN_PAIR;
    assign single = ctrl[4:3] == bzfo_pkg::BZFO_PIN_SINGLE;
    always_comb begin
        next_ctrl = ctrl;
        next_dir = dir;
        next_dat = dat;
        if (hit && avs_address_i == `BZFO_OFS_PWM_CTRL) next_ctrl = avs_writedata_i[7:0];
        if (hit && avs_address_i == `BZFO_OFS_PORT_DIR) next_dir = avs_writedata_i[7:6];
        if (hit && avs_address_i == `BZFO_OFS_PORT_DATA) next_dat = avs_writedata_i[7:6];
    end
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl <= `BZFO_RST_PWM_CTRL;
            dir <= `BZFO_RST_PORT_DIR;
            dat <= `BZFO_RST_PORT_DATA;
        end else begin
            ctrl <= next_ctrl;
            dir <= next_dir;
            dat <= next_dat;
        end
    end
    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_wait_go;
        avs_waitrequest_o ##1 !avs_waitrequest_o;
    endsequence
    a_dir6_input_wins: assert property (port_a_bit6_oe_o == !$past(dir[0]))
        else $error("bit6 enable disagrees with direction");
    a_dir7_input_wins: assert property (port_a_bit7_oe_o == !$past(dir[1]))
        else $error("bit7 enable disagrees with direction");
    a_pair_inverse: assert property ($past(pair && dir == 2'h0 && dat[0]) |-> port_a_bit7_o == !port_a_bit6_o)
        else $error("pair outputs not inverse");
    a_pair_off_low: assert property ($past(pair && dir == 2'h0 && !dat[0]) |-> !port_a_bit6_o && !port_a_bit7_o)
        else $error("pair outputs not low while gated off");
    a_bit7_own_data: assert property ($past(!dir[1] && (dir[0] || !pair)) |-> port_a_bit7_o == $past(dat[1]))
        else $error("bit7 not driven from its data bit");
    a_bit6_plain_io: assert property ($past(!dir[0] && !pair && !single) |-> port_a_bit6_o == $past(dat[0]))
        else $error("bit6 not plain output in io mode");
    a_single_off_low: assert property ($past(single && !dir[0] && !dat[0]) |-> !port_a_bit6_o)
        else $error("single tone pin not low while gated off");
    a_bus_one_wait: assert property ($rose(avs_read_i | avs_write_i) |-> s_wait_go)
        else $error("access did not take exactly one wait cycle");
    a_read_upper_zero: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
endmodule // bzfo_assertions

bind bzfo_top bzfo_assertions i_chk (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .port_a_bit6_o(port_a_bit6_o), .port_a_bit6_oe_o(port_a_bit6_oe_o), .port_a_bit7_o(port_a_bit7_o),
    .port_a_bit7_oe_o(port_a_bit7_oe_o));

/* File: testbench/bzfo_buzzer_model.sv */
// Buzzer and external circuit on the two shared pins; measures the tone period.
`timescale 1ns/10ps
module bzfo_buzzer_model (
    input  wire logic sys_clk_i,
    input  wire logic pin6_i,
    input  wire logic pin6_oe_i,
    input  wire logic pin7_i,
    input  wire logic pin7_oe_i,
    input  wire logic ext6_i,
    input  wire logic ext7_i,
    output logic      wire6_o,
    output logic      wire7_o,
    output int        period_o
);
    int   cnt = 0;
    int   per_q = 0;
    logic last = 1'b0;
    // The line follows the block while it drives, else the outside level.
    assign wire6_o = pin6_oe_i ? pin6_i : ext6_i;
    assign wire7_o = pin7_oe_i ? pin7_i : ext7_i;
    assign period_o = per_q;
    always @(posedge sys_clk_i) begin
        cnt <= cnt + 1;
        last <= wire6_o;
        if (wire6_o && !last) begin
            per_q <= cnt + 1;
            cnt <= 0;
        end
    end
endmodule // bzfo_buzzer_model

/* File: testbench/tb_buzzer_frequency_output.sv */
// Self-checking bench for the buzzer tone block.
`timescale 1ns/10ps
`include "bzfo_defines.svh"
module tb_buzzer_frequency_output;
    logic        sys_clk_i = 1'b0, nrst_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [3:0]  avs_address_i = 4'h0, avs_byteenable_i = 4'hF;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
    logic        avs_waitrequest_o, xtal = 1'b0, lrc = 1'b0, ext6 = 1'b0, ext7 = 1'b1;
    logic        w6, w7, o6, oe6, o7, oe7;
    int          period, fail_count = 0, checked = 0, tbc = 0, seed = 88, i;
    logic [31:0] expq[$];

    bzfo_top i_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .ext_low_xtal_i(xtal), .int_low_rc_i(lrc),
        .port_a_bit6_i(w6), .port_a_bit6_o(o6), .port_a_bit6_oe_o(oe6),
        .port_a_bit7_i(w7), .port_a_bit7_o(o7), .port_a_bit7_oe_o(oe7));
    bzfo_buzzer_model i_buzz (.sys_clk_i(sys_clk_i), .pin6_i(o6), .pin6_oe_i(oe6), .pin7_i(o7),
        .pin7_oe_i(oe7), .ext6_i(ext6), .ext7_i(ext7), .wire6_o(w6), .wire7_o(w7), .period_o(period));

    always #2.5 sys_clk_i = ~sys_clk_i;
    // Slow time-base sources: crystal rises every 6 cycles, RC every 10.
    always @(posedge sys_clk_i) begin
        tbc <= tbc + 1;
        xtal <= (tbc % 6) < 3;
        lrc <= (tbc % 10) < 5;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task wrap_up;
        if (fail_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic bus(input bit we, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be,
                       input logic [7:0] e);
        @(posedge sys_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= {24'h000000, d};
        avs_byteenable_i <= be;
        avs_write_i <= we;
        avs_read_i <= !we;
        if (!we) expq.push_back({24'h000000, e});
        do begin
            @(posedge sys_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    task automatic tone(input logic [1:0] src, input logic [2:0] code, input int per);
        bus(1'b1, `BZFO_OFS_TB_SRC, {6'h00, src}, 4'hF, 8'h00);
        bus(1'b1, `BZFO_OFS_PWM_CTRL, {5'h01, code}, 4'hF, 8'h00);
        repeat (3 * per + 8) @(posedge sys_clk_i);
        check("tone period", 32'(period), 32'(per));
    endtask

    // Each completed read is compared with the oldest noted expectation.
    always @(posedge sys_clk_i)
        if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0)
            check("readdata", avs_readdata_o, expq.pop_front());

    initial begin
        repeat (40000) @(posedge sys_clk_i);
        fail_count++;
        wrap_up;
    end

    initial begin
        repeat (10) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        bus(1'b0, `BZFO_OFS_PWM_CTRL, 8'h00, 4'hF, 8'h00);
        bus(1'b0, `BZFO_OFS_PORT_DIR, 8'h00, 4'hF, 8'hC0);
        bus(1'b0, `BZFO_OFS_TB_SRC, 8'h00, 4'hF, 8'h00);
        bus(1'b1, 4'h2, 8'hFF, 4'hF, 8'h00);
        bus(1'b0, 4'h2, 8'h00, 4'hF, 8'h00);
        bus(1'b1, `BZFO_OFS_PWM_CTRL, 8'hA5, 4'hE, 8'h00);
        bus(1'b0, `BZFO_OFS_PWM_CTRL, 8'h00, 4'hF, 8'h00);
        bus(1'b1, `BZFO_OFS_PWM_CTRL, 8'hA5, 4'hF, 8'h00);
        bus(1'b0, `BZFO_OFS_PWM_CTRL, 8'h00, 4'hF, 8'hA5);
        bus(1'b1, `BZFO_OFS_PORT_DIR, 8'h80, 4'hF, 8'h00);
        bus(1'b1, `BZFO_OFS_PORT_DATA, 8'h40, 4'hF, 8'h00);
        for (i = 0; i < 8; i++) tone(2'h2, 3'(i), 4 << (i + 2));
        tone(2'h0, 3'h0, 24);
        tone(2'h1, 3'h0, 40);
        bus(1'b1, `BZFO_OFS_PWM_CTRL, 8'h18, 4'hF, 8'h00);
        bus(1'b1, `BZFO_OFS_PORT_DIR, 8'h00, 4'hF, 8'h00);
        repeat (20) @(posedge sys_clk_i);
        check("pair enables", {30'h0, oe7, oe6}, 32'h3);
        bus(1'b1, `BZFO_OFS_PORT_DATA, 8'h80, 4'hF, 8'h00);
        repeat (3) @(posedge sys_clk_i);
        check("pair off", {30'h0, o7, o6}, 32'h0);
        bus(1'b1, `BZFO_OFS_PORT_DIR, 8'h40, 4'hF, 8'h00);
        repeat (3) @(posedge sys_clk_i);
        check("bit7 own data", {30'h0, o7, oe6}, 32'h2);
        for (i = 0; i < 30; i++) begin
            bus(1'b1, `BZFO_OFS_PWM_CTRL, 8'($random(seed)), 4'hF, 8'h00);
            bus(1'b1, `BZFO_OFS_PORT_DIR, 8'($random(seed)), 4'($random(seed)), 8'h00);
            bus(1'b1, `BZFO_OFS_PORT_DATA, 8'($random(seed)), 4'hF, 8'h00);
            ext6 <= 1'($random(seed));
            ext7 <= 1'($random(seed));
            repeat (6) @(posedge sys_clk_i);
        end
        wrap_up;
    end
endmodule // tb_buzzer_frequency_output
